// *** rtl/tlp_pkg.sv ***
package tlp_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_ENABLE   = 8'h00;
  localparam logic [7:0] ADDR_PRIO     = 8'h04;
  localparam logic [7:0] ADDR_ENABLE2  = 8'h08;
  localparam logic [7:0] ADDR_WDCTRL   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_EVT      = 8'h14;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h18;

  localparam int GLOBAL_EN_BIT = 7;
  localparam logic [7:0] ENABLE_RST  = 8'h00;
  localparam logic [7:0] PRIO_RST    = 8'h00;
  localparam logic [7:0] ENABLE2_RST = 8'h00;
  localparam logic [7:0] WDCTRL_RST  = 8'h00;

  // ****************************************************************
  // Sources in polling order, index 0 polled first
  // ****************************************************************
  localparam int NSRC   = 11;
  localparam int SRC_PSM = 0;
  localparam int SRC_WD  = 1;
  localparam int SRC_EX0 = 2;
  localparam int SRC_ADC = 3;
  localparam int SRC_T0  = 4;
  localparam int SRC_EX1 = 5;
  localparam int SRC_T1  = 6;
  localparam int SRC_SS  = 7;
  localparam int SRC_URT = 8;
  localparam int SRC_T2  = 9;
  localparam int SRC_TIC = 10;

  localparam logic [15:0] VEC_EX0 = 16'h0003;
  localparam logic [15:0] VEC_T0  = 16'h000b;
  localparam logic [15:0] VEC_EX1 = 16'h0013;
  localparam logic [15:0] VEC_T1  = 16'h001b;
  localparam logic [15:0] VEC_URT = 16'h0023;
  localparam logic [15:0] VEC_T2  = 16'h002b;
  localparam logic [15:0] VEC_ADC = 16'h0033;
  localparam logic [15:0] VEC_SS  = 16'h003b;
  localparam logic [15:0] VEC_PSM = 16'h0043;
  localparam logic [15:0] VEC_TIC = 16'h0053;
  localparam logic [15:0] VEC_WD  = 16'h005b;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_JUMP = 2'b10
  } tlp_state_e;

endpackage

// *** rtl/tlp_arbiter.sv ***
`timescale 1ns/1ns
// Combinational pick of one winner among qualified requests
module tlp_arbiter
(
  input  wire logic [10:0] req,
  input  wire logic [10:0] high,
  input  wire logic [1:0]  active,
  output logic             win_valid,
  output logic [3:0]       win_idx,
  output logic             win_high
);

  // First set bit in polling order
  function automatic logic [4:0] first_set(input logic [10:0] v);
    logic [4:0] r;
    r = 5'h1f;
    for (int i = tlp_pkg::NSRC - 1; i >= 0; i--)
    begin
      if (v[i])
        r = 5'(i);
    end
    return r;
  endfunction

  logic [10:0] hi_req;
  logic [10:0] lo_req;
  logic [4:0]  hi_pick;
  logic [4:0]  lo_pick;
  logic        hi_ok;
  logic        lo_ok;

  assign hi_req  = req & high;
  assign lo_req  = req & ~high;
  assign hi_pick = first_set(hi_req);
  assign lo_pick = first_set(lo_req);
  assign hi_ok   = (|hi_req) && !active[1];
  assign lo_ok   = (|lo_req) && (active == 2'b00);

  always_comb
  begin
    win_valid = 1'b0;
    win_idx   = 4'h0;
    win_high  = 1'b0;
    if (hi_ok)
    begin
      win_valid = 1'b1;
      win_idx   = hi_pick[3:0];
      win_high  = 1'b1;
    end
    else if (lo_ok)
    begin
      win_valid = 1'b1;
      win_idx   = lo_pick[3:0];
    end
  end

endmodule

// *** rtl/tlp_top.sv ***
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ns
// Two-level interrupt prioritizer with APB register access
module tlp_top
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        supply_monitor_request,
  input  wire logic        watchdog_timeout,
  input  wire logic        external0_request,
  input  wire logic        converter_ready_request,
  input  wire logic        timer0_overflow_request,
  input  wire logic        external1_request,
  input  wire logic        timer1_overflow_request,
  input  wire logic        sync_serial_request,
  input  wire logic        uart_rx_tx_request,
  input  wire logic        timer2_request,
  input  wire logic        interval_counter_request,
  input  wire logic        core_ack,
  input  wire logic        core_reti,
  output logic             irq_req,
  output logic             push_pc,
  output logic             load_pc,
  output logic [15:0]      vector_addr,
  output logic             watchdog_reset,
  output logic             irq_out
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0]  enable_q;
  logic [7:0]  prio_q;
  logic [7:0]  enable2_q;
  logic [7:0]  wdctrl_q;
  logic [2:0]  evt_q;
  logic [2:0]  evt_mask_q;
  logic [1:0]  active_q;
  logic        wd_pend_q;
  tlp_pkg::tlp_state_e state_q;
  logic [3:0]  sel_idx_q;
  logic        sel_high_q;

  logic        wr_en;
  logic        rd_en;
  logic        watchdog_irq_select;
  logic        wd_timeout_nz;
  logic        global_irq_enable;
  logic        watchdog_request;
  logic        wd_taken;
  logic [10:0] raw;
  logic [10:0] src_en;
  logic [10:0] high;
  logic [10:0] req;
  logic        win_valid;
  logic [3:0]  win_idx;
  logic        win_high;
  logic [2:0]  evt_set;
  logic [31:0] rd_mux;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // Control bit 0: select, bits 7:1: watchdog timeout setting
  assign watchdog_irq_select = wdctrl_q[0];
  assign wd_timeout_nz       = |wdctrl_q[7:1];
  assign global_irq_enable   = enable_q[tlp_pkg::GLOBAL_EN_BIT];

  assign watchdog_request = watchdog_timeout && watchdog_irq_select
                            && wd_timeout_nz;

  assign raw[tlp_pkg::SRC_PSM] = supply_monitor_request;
  assign raw[tlp_pkg::SRC_WD]  = watchdog_request || wd_pend_q;
  assign raw[tlp_pkg::SRC_EX0] = external0_request;
  assign raw[tlp_pkg::SRC_ADC] = converter_ready_request;
  assign raw[tlp_pkg::SRC_T0]  = timer0_overflow_request;
  assign raw[tlp_pkg::SRC_EX1] = external1_request;
  assign raw[tlp_pkg::SRC_T1]  = timer1_overflow_request;
  assign raw[tlp_pkg::SRC_SS]  = sync_serial_request;
  assign raw[tlp_pkg::SRC_URT] = uart_rx_tx_request;
  assign raw[tlp_pkg::SRC_T2]  = timer2_request;
  assign raw[tlp_pkg::SRC_TIC] = interval_counter_request;

  // Per-source enables gated by the global bit; watchdog bypasses it
  always_comb
  begin
    src_en = 11'h000;
    src_en[tlp_pkg::SRC_PSM] = enable2_q[1] && global_irq_enable;
    src_en[tlp_pkg::SRC_WD]  = 1'b1;
    src_en[tlp_pkg::SRC_EX0] = enable_q[0] && global_irq_enable;
    src_en[tlp_pkg::SRC_ADC] = enable_q[6] && global_irq_enable;
    src_en[tlp_pkg::SRC_T0]  = enable_q[1] && global_irq_enable;
    src_en[tlp_pkg::SRC_EX1] = enable_q[2] && global_irq_enable;
    src_en[tlp_pkg::SRC_T1]  = enable_q[3] && global_irq_enable;
    src_en[tlp_pkg::SRC_SS]  = enable2_q[0] && global_irq_enable;
    src_en[tlp_pkg::SRC_URT] = enable_q[4] && global_irq_enable;
    src_en[tlp_pkg::SRC_T2]  = enable_q[5] && global_irq_enable;
    src_en[tlp_pkg::SRC_TIC] = enable2_q[2] && global_irq_enable;
  end

  always_comb
  begin
    high = 11'h000;
    high[tlp_pkg::SRC_PSM] = enable2_q[5];
    high[tlp_pkg::SRC_WD]  = 1'b1;
    high[tlp_pkg::SRC_EX0] = prio_q[0];
    high[tlp_pkg::SRC_ADC] = prio_q[6];
    high[tlp_pkg::SRC_T0]  = prio_q[1];
    high[tlp_pkg::SRC_EX1] = prio_q[2];
    high[tlp_pkg::SRC_T1]  = prio_q[3];
    high[tlp_pkg::SRC_SS]  = enable2_q[4];
    high[tlp_pkg::SRC_URT] = prio_q[4];
    high[tlp_pkg::SRC_T2]  = prio_q[5];
    high[tlp_pkg::SRC_TIC] = enable2_q[6];
  end

  assign req = raw & src_en;

  tlp_arbiter u_arb
  (
    .req       (req),
    .high      (high),
    .active    (active_q),
    .win_valid (win_valid),
    .win_idx   (win_idx),
    .win_high  (win_high)
  );

  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    case (idx)
      4'h0:    return tlp_pkg::VEC_PSM;
      4'h1:    return tlp_pkg::VEC_WD;
      4'h2:    return tlp_pkg::VEC_EX0;
      4'h3:    return tlp_pkg::VEC_ADC;
      4'h4:    return tlp_pkg::VEC_T0;
      4'h5:    return tlp_pkg::VEC_EX1;
      4'h6:    return tlp_pkg::VEC_T1;
      4'h7:    return tlp_pkg::VEC_SS;
      4'h8:    return tlp_pkg::VEC_URT;
      4'h9:    return tlp_pkg::VEC_T2;
      4'ha:    return tlp_pkg::VEC_TIC;
      default: return 16'h0000;
    endcase
  endfunction

  // ****************************************************************
  // Watchdog request held until the core takes it
  // ****************************************************************
  // A slow core must not lose a one-cycle timeout pulse; a new
  // timeout in the accept cycle wins over the clear
  assign wd_taken = (state_q == tlp_pkg::ST_PUSH)
                    && (sel_idx_q == 4'(tlp_pkg::SRC_WD));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wd_pend_q <= 1'b0;
    else if (watchdog_request)
      wd_pend_q <= 1'b1;
    else if (wd_taken)
      wd_pend_q <= 1'b0;
  end

  // ****************************************************************
  // Accept sequence: request, push, jump
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= tlp_pkg::ST_IDLE;
      sel_idx_q   <= 4'h0;
      sel_high_q  <= 1'b0;
      irq_req     <= 1'b0;
      push_pc     <= 1'b0;
      load_pc     <= 1'b0;
      vector_addr <= 16'h0000;
    end
    else
    begin
      push_pc <= 1'b0;
      load_pc <= 1'b0;
      case (state_q)
        tlp_pkg::ST_IDLE:
        begin
          irq_req <= win_valid;
          // Winner may change until the core takes it
          if (win_valid)
          begin
            sel_idx_q   <= win_idx;
            sel_high_q  <= win_high;
            vector_addr <= vec_of(win_idx);
          end
          if (core_ack && irq_req)
          begin
            irq_req <= 1'b0;
            push_pc <= 1'b1;
            state_q <= tlp_pkg::ST_PUSH;
          end
        end
        tlp_pkg::ST_PUSH:
        begin
          load_pc <= 1'b1;
          state_q <= tlp_pkg::ST_JUMP;
        end
        tlp_pkg::ST_JUMP:
          state_q <= tlp_pkg::ST_IDLE;
        default:
          state_q <= tlp_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Levels in service, freed one at a time on return
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_q    <= 2'b00;
    end
    else if (state_q == tlp_pkg::ST_PUSH)
    begin
      if (sel_high_q)
        active_q[1] <= 1'b1;
      else
        active_q[0] <= 1'b1;
    end
    else if (core_reti)
    begin
      // Return ends the most recent, highest level
      if (active_q[1])
        active_q[1] <= 1'b0;
      else
        active_q[0] <= 1'b0;
    end
  end

  // ****************************************************************
  // Event flags: 0 accept, 1 watchdog irq, 2 watchdog reset
  // ****************************************************************
  assign evt_set = {watchdog_timeout && !watchdog_request,
                    watchdog_request,
                    state_q == tlp_pkg::ST_PUSH};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      evt_q <= 3'h0;
    else if (wr_en && paddr == tlp_pkg::ADDR_EVT)
      evt_q <= (evt_q & ~pwdata[2:0]) | evt_set; // Set beats clear
    else
      evt_q <= evt_q | evt_set;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_out        <= 1'b0;
      watchdog_reset <= 1'b0;
    end
    else
    begin
      irq_out        <= |(evt_q & evt_mask_q);
      // Timeout resets the device unless routed as interrupt
      watchdog_reset <= watchdog_timeout && !watchdog_request;
    end
  end

  // ****************************************************************
  // APB slave, zero wait states
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_q   <= tlp_pkg::ENABLE_RST;
      prio_q     <= tlp_pkg::PRIO_RST;
      enable2_q  <= tlp_pkg::ENABLE2_RST;
      wdctrl_q   <= tlp_pkg::WDCTRL_RST;
      evt_mask_q <= 3'h0;
    end
    else if (wr_en)
    begin
      case (paddr)
        tlp_pkg::ADDR_ENABLE:   enable_q   <= pwdata[7:0];
        tlp_pkg::ADDR_PRIO:     prio_q     <= {1'b0, pwdata[6:0]};
        tlp_pkg::ADDR_ENABLE2:  enable2_q  <= {1'b0, pwdata[6:4],
                                               1'b0, pwdata[2:0]};
        tlp_pkg::ADDR_WDCTRL:   wdctrl_q   <= pwdata[7:0];
        tlp_pkg::ADDR_EVT_MASK: evt_mask_q <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  always_comb
  begin
    case (paddr)
      tlp_pkg::ADDR_ENABLE:   rd_mux = {24'h0, enable_q};
      tlp_pkg::ADDR_PRIO:     rd_mux = {24'h0, prio_q};
      tlp_pkg::ADDR_ENABLE2:  rd_mux = {24'h0, enable2_q};
      tlp_pkg::ADDR_WDCTRL:   rd_mux = {24'h0, wdctrl_q};
      tlp_pkg::ADDR_STATUS:   rd_mux = {16'h0, 1'b0, sel_idx_q,
                                        active_q, state_q,
                                        vector_addr[6:0]};
      tlp_pkg::ADDR_EVT:      rd_mux = {29'h0, evt_q};
      tlp_pkg::ADDR_EVT_MASK: rd_mux = {29'h0, evt_mask_q};
      default:                rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr > tlp_pkg::ADDR_EVT_MASK
                                      || paddr[1:0] != 2'b00);
      if (rd_en)
        prdata <= rd_mux;
    end
  end

endmodule

// *** tb/tlp_assertions.sv ***
`timescale 1ns/1ns
// ********
// Core handshake and register bus checks
// ********
module tlp_checker
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        core_ack,
  input wire logic        irq_req,
  input wire logic        push_pc,
  input wire logic        load_pc,
  input wire logic [15:0] vector_addr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_push_after_ack: assert property (irq_req && core_ack |=> push_pc && !irq_req)
    else $error("no push after ack");
  a_load_after_push: assert property (push_pc |=> load_pc && !push_pc)
    else $error("no load after push");
  a_push_has_cause: assert property (push_pc |-> $past(irq_req) && $past(core_ack))
    else $error("push without ack");
  a_vector_legal: assert property (irq_req |-> vector_addr inside
    {16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
     16'h0033, 16'h003b, 16'h0043, 16'h0053, 16'h005b})
    else $error("illegal vector");
  a_vector_held: assert property (load_pc |-> $stable(vector_addr))
    else $error("vector moved before load");
  a_quiet_in_entry: assert property (push_pc |-> !irq_req [*3])
    else $error("offer during entry");
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready in access");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_bad_addr_err: assert property (pready && (paddr[1:0] != 2'b00
    || paddr > 8'h18) |-> pslverr)
    else $error("no error on bad address");
  a_good_addr_ok: assert property (pready && paddr[1:0] == 2'b00
    && paddr <= 8'h18 |-> !pslverr)
    else $error("error on good address");
endmodule

bind tlp_top tlp_checker u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .core_ack(core_ack), .irq_req(irq_req), .push_pc(push_pc),
  .load_pc(load_pc), .vector_addr(vector_addr));

// *** tb/tlp_core_model.sv ***
`timescale 1ns/1ns
// ********
// Core side: takes offers, pushes, jumps
// ********
module tlp_core_model
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        irq_req,
  input  wire logic        push_pc,
  input  wire logic        load_pc,
  input  wire logic [15:0] vector_addr,
  input  wire logic [3:0]  ack_delay,
  output logic             core_ack,
  output logic             core_reti,
  output logic [15:0]      last_vec,
  output logic [7:0]       taken,
  output logic             order_err
);
  logic [3:0] wait_q;
  logic       pushed_q;
  initial core_reti = 1'b0;
  // Slow answers keep the offer open so a later source can race it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_ack <= 1'b0;
      wait_q   <= 4'h0;
    end
    else if (irq_req && !core_ack && wait_q == ack_delay)
    begin
      core_ack <= 1'b1;
      wait_q   <= 4'h0;
    end
    else
    begin
      core_ack <= 1'b0;
      if (irq_req && !core_ack)
        wait_q <= wait_q + 4'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pushed_q  <= 1'b0;
      last_vec  <= 16'h0000;
      taken     <= 8'h00;
      order_err <= 1'b0;
    end
    else
    begin
      pushed_q <= push_pc;
      if (load_pc)
      begin
        last_vec  <= vector_addr;
        taken     <= taken + 8'h01;
        order_err <= order_err | !pushed_q;
      end
    end
  end
  task automatic ret();
    @(posedge clk);
    core_reti <= 1'b1;
    @(posedge clk);
    core_reti <= 1'b0;
  endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`define CHK(act, exp) \
  begin \
    comparisons++; \
    if ((act) !== (exp)) \
    begin \
      miscompares++; \
      $display("ERROR t=%0t got %h exp %h", $time, act, exp); \
    end \
  end
module tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, wd_to = 1'b0, er;
  logic [7:0]  paddr = 8'h00, taken;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [10:0] rq = 11'h000;
  logic [3:0]  ack_delay = 4'h0;
  logic        core_ack, core_reti, irq_req, push_pc, load_pc, order_err;
  logic        watchdog_reset, irq_out;
  logic [15:0] vector_addr, last_vec;
  logic [15:0] vt [11];
  int          miscompares = 0, comparisons = 0, n;

  always #4 clk = ~clk;
  tlp_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_monitor_request(rq[0]),
    .watchdog_timeout(wd_to), .external0_request(rq[2]),
    .converter_ready_request(rq[3]), .timer0_overflow_request(rq[4]),
    .external1_request(rq[5]), .timer1_overflow_request(rq[6]),
    .sync_serial_request(rq[7]), .uart_rx_tx_request(rq[8]),
    .timer2_request(rq[9]), .interval_counter_request(rq[10]),
    .core_ack(core_ack), .core_reti(core_reti), .irq_req(irq_req),
    .push_pc(push_pc), .load_pc(load_pc), .vector_addr(vector_addr),
    .watchdog_reset(watchdog_reset), .irq_out(irq_out));
  tlp_core_model core (.clk(clk), .rst_n(rst_n), .irq_req(irq_req),
    .push_pc(push_pc), .load_pc(load_pc), .vector_addr(vector_addr),
    .ack_delay(ack_delay), .core_ack(core_ack), .core_reti(core_reti),
    .last_vec(last_vec), .taken(taken), .order_err(order_err));

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
      miscompares++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic take(input logic [15:0] e);
    logic [7:0] t0;
    int k;
    t0 = taken;
    k = 0;
    while (taken === t0 && k < 100)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 100)
      miscompares++;
    `CHK(last_vec, e)
  endtask
  task automatic pulse_wd();
    @(posedge clk);
    wd_to <= 1'b1;
    @(posedge clk);
    wd_to <= 1'b0;
  endtask
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #160000;
    miscompares++;
    complete_run();
  end

  initial
  begin
    vt = '{tlp_pkg::VEC_PSM, tlp_pkg::VEC_WD, tlp_pkg::VEC_EX0,
           tlp_pkg::VEC_ADC, tlp_pkg::VEC_T0, tlp_pkg::VEC_EX1,
           tlp_pkg::VEC_T1, tlp_pkg::VEC_SS, tlp_pkg::VEC_URT,
           tlp_pkg::VEC_T2, tlp_pkg::VEC_TIC};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h00, 32'h0);
    rchk(8'h04, 32'h0);
    rchk(8'h0c, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    `CHK({er, rd}, 33'h1_0000_0000)
    apb(1'b1, 8'h00, 32'hff);
    apb(1'b1, 8'h08, 32'h07);
    rchk(8'h08, 32'h07);
    $display("register test done");
    rq <= 11'h7fd;
    for (int i = 0; i < 11; i++)
      if (i != 1)
      begin
        take(vt[i]);
        repeat (4) @(posedge clk);
        `CHK(irq_req, 1'b0)
        rq[i] <= 1'b0;
        core.ret();
      end
    $display("polling test done");
    apb(1'b1, 8'h04, 32'h04);
    apb(1'b1, 8'h00, 32'h7f);
    rq[2] <= 1'b1;
    rq[5] <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(irq_req, 1'b0)
    apb(1'b1, 8'h00, 32'hff);
    take(tlp_pkg::VEC_EX1);
    rq[5] <= 1'b0;
    core.ret();
    take(tlp_pkg::VEC_EX0);
    rq[5] <= 1'b1;
    take(tlp_pkg::VEC_EX1);
    rq <= 11'h000;
    core.ret();
    core.ret();
    $display("preemption test done");
    ack_delay <= 4'h3;
    rq[2] <= 1'b1;
    take(tlp_pkg::VEC_EX0);
    apb(1'b1, 8'h00, 32'h00);
    apb(1'b1, 8'h0c, 32'h01);
    pulse_wd();
    repeat (10) @(posedge clk);
    `CHK(irq_req, 1'b0)
    apb(1'b1, 8'h0c, 32'h03);
    pulse_wd();
    take(tlp_pkg::VEC_WD);
    `CHK(watchdog_reset, 1'b0)
    rq[2] <= 1'b0;
    core.ret();
    core.ret();
    apb(1'b1, 8'h0c, 32'h02);
    pulse_wd();
    n = 0;
    while (watchdog_reset !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    `CHK({watchdog_reset, irq_req}, 2'b10)
    $display("watchdog test done");
    rchk(8'h14, 32'h07);
    apb(1'b1, 8'h18, 32'h00);
    repeat (2) @(posedge clk);
    `CHK(irq_out, 1'b0)
    apb(1'b1, 8'h18, 32'h07);
    repeat (2) @(posedge clk);
    `CHK(irq_out, 1'b1)
    apb(1'b1, 8'h14, 32'h07);
    rchk(8'h14, 32'h00);
    apb(1'b1, 8'h18, 32'h00);
    repeat (2) @(posedge clk);
    `CHK({irq_out, order_err}, 2'b00)
    $display("event test done");
    complete_run();
  end
endmodule
